// file: rfap_reg.sv
// Control register whose fields follow read-write, read-only and reserved access classes.
// Assumes software requests and hardware updates come from logic on the same clock,
// and that the strap value is stable around reset release.
//
// What this block does
// - Read-write field bits readable and writable by software.
// - Hardware and software updates mutually visible.
// - Read-write field initialised before predictable read.
// - Read-only field ignores software writes.
// - Read-only read returns last hardware value.
// - Read-only field loads zero, preset or strap.
// - Undefined-reset field changes only on update.
// - Reserved field ignores every software write.
// - Reserved field always reads as zero.
// - Reserved field resets to zero.
// - Reserved bits dropped, other fields still written.
`timescale 1ns/100ps
`default_nettype none
module rfap_reg
    import rfap_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire rfap_sw_req_t          sw_req,
    input  wire rfap_hw_upd_t          hw_upd,
    input  wire logic [RFAP_EXT_W-1:0] ext_value,
    output rfap_sw_rsp_t               sw_rsp,
    output logic      [RFAP_REG_W-1:0] field_value
);

    rfap_state_t           st_q;
    rfap_state_t           st_d;
    logic [RFAP_REG_W-1:0] sw_wdata_m;
    logic                  load_ext;

    ////////////////////////////////////////////////////////////////////////////
    // Write mask keeps software data off every non-writable field
    assign sw_wdata_m = sw_req.wdata & RFAP_SW_WMASK;
    assign load_ext   = !st_q.boot;

    ////////////////////////////////////////////////////////////////////////////
    // One instance per field, each taking its class from the layout table
    for (genvar i = 0; i < RFAP_NF; i++) begin : g_field
        localparam int unsigned LSB = RFAP_F_LSB[i];
        localparam int unsigned FW  = RFAP_F_W[i];
        logic [FW-1:0] ext_slice;
        if (RFAP_F_EXT[i]) begin : g_ext
            assign ext_slice = ext_value[FW-1:0];
        end else begin : g_noext
            assign ext_slice = '0;
        end
        rfap_field #(
            .W   (FW),
            .CLS (RFAP_F_CLS[i]),
            .RST (RFAP_F_RST[i][FW-1:0]),
            .EXT (RFAP_F_EXT[i])
        ) u_field (
            .clock    (clock),
            .reset_n  (reset_n),
            .load_ext (load_ext),
            .ext_val  (ext_slice),
            .sw_we    (sw_req.wr),
            .sw_wdata (sw_wdata_m[LSB +: FW]),
            .hw_we    (hw_upd.we[i]),
            .hw_wdata (hw_upd.wdata[LSB +: FW]),
            .value    (field_value[LSB +: FW])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path and strap capture; reads are registered so the answer is one cycle late
    always_comb begin
        st_d           = st_q;
        st_d.boot      = 1'b1;  // Straps taken in the first cycle after release
        st_d.rsp.valid = sw_req.rd;
        if (sw_req.rd) begin
            st_d.rsp.rdata = field_value & ~RFAP_RSV_MASK;
        end
    end

    // Straps are never sampled under reset; they load on the first clock after it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q.boot      <= 1'b0;
            st_q.rsp.valid <= 1'b0;
            st_q.rsp.rdata <= RFAP_RST_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    assign sw_rsp = st_q.rsp;

    ////////////////////////////////////////////////////////////////////////////
    // Helper slices for the checks below
    logic [RFAP_F_W[RFAP_FI_RW]-1:0]     v_rw;
    logic [RFAP_F_W[RFAP_FI_RO_ZR]-1:0]  v_zr;
    logic [RFAP_F_W[RFAP_FI_RO_PRE]-1:0] v_pre;
    logic [RFAP_F_W[RFAP_FI_RO_EXT]-1:0] v_ext;
    logic [RFAP_F_W[RFAP_FI_RO_UND]-1:0] v_und;
    logic [RFAP_F_W[RFAP_FI_RSV]-1:0]    v_rsv;
    logic [RFAP_F_W[RFAP_FI_RW]-1:0]     w_rw;
    logic [RFAP_F_W[RFAP_FI_RSV]-1:0]    w_rsv;
    logic [RFAP_F_W[RFAP_FI_RO_ZR]-1:0]  h_zr;

    assign v_rw  = field_value[RFAP_F_LSB[RFAP_FI_RW]     +: RFAP_F_W[RFAP_FI_RW]];
    assign v_zr  = field_value[RFAP_F_LSB[RFAP_FI_RO_ZR]  +: RFAP_F_W[RFAP_FI_RO_ZR]];
    assign v_pre = field_value[RFAP_F_LSB[RFAP_FI_RO_PRE] +: RFAP_F_W[RFAP_FI_RO_PRE]];
    assign v_ext = field_value[RFAP_F_LSB[RFAP_FI_RO_EXT] +: RFAP_F_W[RFAP_FI_RO_EXT]];
    assign v_und = field_value[RFAP_F_LSB[RFAP_FI_RO_UND] +: RFAP_F_W[RFAP_FI_RO_UND]];
    assign v_rsv = field_value[RFAP_F_LSB[RFAP_FI_RSV]    +: RFAP_F_W[RFAP_FI_RSV]];
    assign w_rw  = sw_req.wdata[RFAP_F_LSB[RFAP_FI_RW]    +: RFAP_F_W[RFAP_FI_RW]];
    assign w_rsv = sw_req.wdata[RFAP_F_LSB[RFAP_FI_RSV]   +: RFAP_F_W[RFAP_FI_RSV]];
    assign h_zr  = hw_upd.wdata[RFAP_F_LSB[RFAP_FI_RO_ZR] +: RFAP_F_W[RFAP_FI_RO_ZR]];

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////
    // Software write to the read-write field lands, unless hardware writes it too
    property p_rw_sw_write;
        sw_req.wr && !hw_upd.we[RFAP_FI_RW] |=> v_rw == $past(w_rw);
    endproperty
    a_rw_sw_write: assert property (p_rw_sw_write) else $error("rw field missed sw write");

    // Hardware update of a read-write field shows on a read issued one cycle later
    property p_rw_hw_visible;
        hw_upd.we[RFAP_FI_RW] ##1 (sw_req.rd && !sw_req.wr && !hw_upd.we[RFAP_FI_RW])
            |=> sw_rsp.rdata[RFAP_F_W[RFAP_FI_RW]-1:0] == $past(hw_upd.wdata[RFAP_F_W[RFAP_FI_RW]-1:0], 2);
    endproperty
    a_rw_hw_visible: assert property (p_rw_hw_visible) else $error("hw update not read back");

    // Software writes leave a read-only field alone
    property p_ro_ignores_sw;
        sw_req.wr && !hw_upd.we[RFAP_FI_RO_ZR] && st_q.boot |=> $stable(v_zr);
    endproperty
    a_ro_ignores_sw: assert property (p_ro_ignores_sw) else $error("ro field changed by sw");

    // Read of a read-only field returns the value hardware last put there
    property p_ro_read_last_hw;
        hw_upd.we[RFAP_FI_RO_ZR] ##1 (sw_req.rd && !hw_upd.we[RFAP_FI_RO_ZR])
            |=> sw_rsp.rdata[RFAP_F_LSB[RFAP_FI_RO_ZR] +: RFAP_F_W[RFAP_FI_RO_ZR]] == $past(h_zr, 2);
    endproperty
    a_ro_read_last_hw: assert property (p_ro_read_last_hw) else $error("ro read not last hw value");

    // Fields hold their zero and preset values right after reset, and the strap value one clock later
    property p_ro_reset_vals;
        !st_q.boot |-> v_zr == RFAP_RST_ZERO[RFAP_F_W[RFAP_FI_RO_ZR]-1:0]
                    && v_pre == RFAP_RST_PRESET[RFAP_F_W[RFAP_FI_RO_PRE]-1:0];
    endproperty
    a_ro_reset_vals: assert property (p_ro_reset_vals) else $error("ro reset value wrong");

    property p_ext_load;
        !st_q.boot |=> v_ext == $past(ext_value);
    endproperty
    a_ext_load: assert property (p_ext_load) else $error("strap value not loaded");

    // Undefined-reset field moves only on its own hardware update
    property p_und_only_hw;
        !hw_upd.we[RFAP_FI_RO_UND] |=> $stable(v_und);
    endproperty
    a_und_only_hw: assert property (p_und_only_hw) else $error("undefined field changed alone");

    // Reserved field is zero at all times and on every read
    property p_rsv_zero;
        v_rsv == '0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved field not zero");

    property p_rsv_read_zero;
        sw_rsp.valid |-> (sw_rsp.rdata & RFAP_RSV_MASK) == RFAP_RST_ZERO;
    endproperty
    a_rsv_read_zero: assert property (p_rsv_read_zero) else $error("reserved read nonzero");

    // Nonzero reserved bits in a write do not stop the other fields updating
    property p_rsv_write_partial;
        sw_req.wr && w_rsv != '0 && !hw_upd.we[RFAP_FI_RW] |=> v_rw == $past(w_rw) && v_rsv == '0;
    endproperty
    a_rsv_write_partial: assert property (p_rsv_write_partial) else $error("partial write lost");

    // Every read is answered exactly one cycle later, and only then
    property p_read_answer;
        sw_req.rd |=> sw_rsp.valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    property p_no_spurious;
        !sw_req.rd |=> !sw_rsp.valid;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("spurious read answer");

    // Read-write field comes out of reset at a defined value, so a first read is predictable
    property p_rw_reset_init;
        !st_q.boot |-> v_rw == RFAP_RST_ZERO[RFAP_F_W[RFAP_FI_RW]-1:0];
    endproperty
    a_rw_reset_init: assert property (p_rw_reset_init) else $error("rw field not initialised");

    // A write with reserved bits set leaves every non-writable field untouched
    property p_rsv_write_ignored;
        sw_req.wr && w_rsv != '0 && hw_upd.we == '0 && st_q.boot |=> $stable(field_value & ~RFAP_SW_WMASK);
    endproperty
    a_rsv_write_ignored: assert property (p_rsv_write_ignored) else $error("reserved write had effect");

    // A plain software write changes exactly the bits its mask allows
    property p_sw_write_mask;
        sw_req.wr && hw_upd.we == '0 && st_q.boot
            |=> field_value == (($past(field_value) & ~RFAP_SW_WMASK) | ($past(sw_req.wdata) & RFAP_SW_WMASK));
    endproperty
    a_sw_write_mask: assert property (p_sw_write_mask) else $error("write mask not applied");

    ////////////////////////////////////////////////////////////////////////////
    // Main scenarios
    c_sw_write: cover property (sw_req.wr ##1 sw_req.rd ##1 sw_rsp.valid);
    c_hw_over_sw: cover property (sw_req.wr && hw_upd.we[RFAP_FI_RW]);
    c_rsv_nonzero: cover property (sw_req.wr && w_rsv != '0);
    c_ro_update: cover property (hw_upd.we[RFAP_FI_RO_UND] ##1 sw_req.rd);
    c_strap_load: cover property (!st_q.boot ##1 st_q.boot);

endmodule
`default_nettype wire

// file: rfap_pkg.sv
// Constants, field layout and carrier types of the control register with field access classes.
// Assumes one 200 MHz core clock and a single register of fixed layout.
package rfap_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Access classes of a field
    typedef enum logic [1:0] {
        RFAP_CLS_RW,
        RFAP_CLS_RO,
        RFAP_CLS_RSV
    } rfap_class_t;

    ////////////////////////////////////////////////////////////////////////////
    // Register and field layout
    localparam int unsigned RFAP_REG_W = 32;
    localparam int unsigned RFAP_NF    = 6;
    localparam int unsigned RFAP_EXT_W = 4;

    // Field indices
    localparam int unsigned RFAP_FI_RW     = 0;  // Software and hardware read-write
    localparam int unsigned RFAP_FI_RO_ZR  = 1;  // Hardware-updated, reset to zero
    localparam int unsigned RFAP_FI_RO_PRE = 2;  // Hardware-updated, preset at reset
    localparam int unsigned RFAP_FI_RO_EXT = 3;  // Loaded from straps after reset
    localparam int unsigned RFAP_FI_RO_UND = 4;  // Hardware-updated, reset to zero in this model
    localparam int unsigned RFAP_FI_RSV    = 5;  // Reserved, reads zero

    localparam int unsigned RFAP_F_LSB [RFAP_NF] = '{0, 8, 16, 20, 24, 28};
    localparam int unsigned RFAP_F_W   [RFAP_NF] = '{8, 8, 4, 4, 4, 4};
    localparam rfap_class_t RFAP_F_CLS [RFAP_NF] = '{RFAP_CLS_RW, RFAP_CLS_RO, RFAP_CLS_RO,
                                                     RFAP_CLS_RO, RFAP_CLS_RO, RFAP_CLS_RSV};
    localparam bit          RFAP_F_EXT [RFAP_NF] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

    // Reset values; the preset value is a plain default
    localparam logic [RFAP_REG_W-1:0] RFAP_RST_ZERO   = 32'h0000_0000;
    localparam logic [RFAP_REG_W-1:0] RFAP_RST_PRESET = 32'h0000_0005;
    localparam logic [RFAP_REG_W-1:0] RFAP_F_RST [RFAP_NF] = '{RFAP_RST_ZERO, RFAP_RST_ZERO,
                                                               RFAP_RST_PRESET, RFAP_RST_ZERO,
                                                               RFAP_RST_ZERO, RFAP_RST_ZERO};

    // Per-register masks derived from the field classes
    localparam logic [RFAP_REG_W-1:0] RFAP_SW_WMASK = 32'h0000_00ff;
    localparam logic [RFAP_REG_W-1:0] RFAP_RSV_MASK = 32'hf000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic                  wr;     // move_to_coprocessor0 write
        logic                  rd;     // Software read
        logic [RFAP_REG_W-1:0] wdata;
    } rfap_sw_req_t;

    typedef struct packed {
        logic                  valid;
        logic [RFAP_REG_W-1:0] rdata;
    } rfap_sw_rsp_t;

    typedef struct packed {
        logic [RFAP_NF-1:0]    we;     // One enable per field
        logic [RFAP_REG_W-1:0] wdata;  // Aligned to register bit positions
    } rfap_hw_upd_t;

    // Top-level state
    typedef struct packed {
        logic         boot;            // Set once straps have been taken
        rfap_sw_rsp_t rsp;
    } rfap_state_t;

endpackage

// file: rfap_field.sv
// One field of the control register, behaving as its access class demands.
// Assumes the parent gives it aligned slices of the software and hardware write data.
`timescale 1ns/100ps
`default_nettype none
module rfap_field
    import rfap_pkg::*;
#(
    parameter int unsigned W   = 8,
    parameter rfap_class_t CLS = RFAP_CLS_RW,
    parameter logic [W-1:0] RST = '0,
    parameter bit          EXT = 1'b0
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         load_ext,
    input  wire logic [W-1:0] ext_val,
    input  wire logic         sw_we,
    input  wire logic [W-1:0] sw_wdata,
    input  wire logic         hw_we,
    input  wire logic [W-1:0] hw_wdata,
    output logic      [W-1:0] value
);

    typedef struct packed {
        logic [W-1:0] val;
    } rfap_fstate_t;

    rfap_fstate_t st_q;
    rfap_fstate_t st_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next value; hardware wins over a same-cycle software write so no event is lost
    always_comb begin
        st_d = st_q;
        if (CLS == RFAP_CLS_RW && sw_we) begin
            st_d.val = sw_wdata;
        end
        if (CLS != RFAP_CLS_RSV && hw_we) begin
            st_d.val = hw_wdata;
        end
        if (EXT && load_ext) begin
            st_d.val = ext_val;
        end
        // Reserved bits never hold anything, whatever is written
        if (CLS == RFAP_CLS_RSV) begin
            st_d.val = '0;
        end
    end

    // Reset puts every field at a known constant
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q.val <= RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign value = st_q.val;

endmodule
`default_nettype wire

// file: rfap_reg_bench.sv
// Self-checking testbench for the control register with field access classes.
// Assumes the rfap_pkg field layout and a registered read answer one cycle after rd.
`timescale 1ns/100ps
`default_nettype none
module rfap_reg_bench
    import rfap_pkg::*;
;
    logic                  clock;
    logic                  reset_n;
    rfap_sw_req_t          sw_req;
    rfap_hw_upd_t          hw_upd;
    logic [RFAP_EXT_W-1:0] ext_value;
    rfap_sw_rsp_t          sw_rsp;
    logic [RFAP_REG_W-1:0] field_value;
    logic [RFAP_REG_W-1:0] model;
    logic [RFAP_REG_W-1:0] read_care;
    int                    miscompares;
    int                    check_count;
    int                    cycles;

    // The undefined-reset field is hidden until hardware has written it
    localparam logic [RFAP_REG_W-1:0] UND_MASK = 32'h0f00_0000;

    rfap_reg i_dut (
        .clock       (clock),
        .reset_n     (reset_n),
        .sw_req      (sw_req),
        .hw_upd      (hw_upd),
        .ext_value   (ext_value),
        .sw_rsp      (sw_rsp),
        .field_value (field_value)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling on run length in case a wait hangs
    always #2.5 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared compare and port drivers; inputs change on the falling edge only
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Read data is checked at the falling edge after the taking edge; an idle cycle
    // always follows so back-to-back calls never re-drive the request in one step
    task automatic sw_op(input logic wr, input logic rd, input logic [31:0] wd, input logic [31:0] exp);
        sw_req = '{wr: wr, rd: rd, wdata: wd};
        @(negedge clock);
        sw_req = '0;
        if (rd) begin
            check("read valid", {31'h0, sw_rsp.valid}, 32'h1);
            check("read data", sw_rsp.rdata & read_care, exp & read_care);
        end
        @(negedge clock);
        if (rd) begin
            check("valid pulse", {31'h0, sw_rsp.valid}, 32'h0);
        end
    endtask

    task automatic hw_op(input logic [5:0] we, input logic [31:0] wd);
        hw_upd = '{we: we, wdata: wd};
        @(negedge clock);
        hw_upd = '0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    // Reset values, then strap load that beats a same-edge hardware update
    task automatic t_reset(input logic [3:0] ext);
        reset_n   = 1'b0;
        ext_value = ext;
        read_care = ~UND_MASK;
        repeat (2) @(negedge clock);
        check("reset value", field_value & ~UND_MASK, 32'h0005_0000);
        check("reset valid", {31'h0, sw_rsp.valid}, 32'h0);
        reset_n = 1'b1;
        hw_op(6'h08, 32'h00f0_0000);
        model = {8'h00, ext, 4'h5, 16'h0000};
        check("strap field", field_value & ~UND_MASK, model);
    endtask

    // Software writes touch only the read-write field
    task automatic t_sw_write();
        sw_op(1'b1, 1'b0, 32'hffff_ffff, 32'h0);
        model[7:0] = 8'hff;
        check("write all ones", field_value & ~UND_MASK, model);
        sw_op(1'b1, 1'b1, 32'hf0f0_f03c, model & ~UND_MASK);
        model[7:0] = 8'h3c;
        check("write old read", field_value & ~UND_MASK, model);
    endtask

    // Hardware updates of every field, reserved one refused
    task automatic t_hw_update();
        hw_op(6'h3f, 32'hfedc_ba98);
        model     = 32'h0edc_ba98;
        read_care = 32'hffff_ffff;
        check("hw update", field_value, model);
        sw_op(1'b0, 1'b1, 32'h0, model);
        sw_op(1'b1, 1'b0, 32'h5a5a_5a5a, 32'h0);
        model[7:0] = 8'h5a;
        check("ro kept", field_value, model);
        sw_op(1'b0, 1'b1, 32'h0, model);
        sw_op(1'b1, 1'b0, sw_rsp.rdata, 32'h0);
        check("write back", field_value, model);
    endtask

    // Hardware wins over a software write of the same field in one cycle
    task automatic t_collide();
        sw_req = '{wr: 1'b1, rd: 1'b0, wdata: 32'h0000_0011};
        hw_upd = '{we: 6'h01, wdata: 32'h7777_7722};
        @(negedge clock);
        sw_req = '0;
        hw_upd = '0;
        model[7:0] = 8'h22;
        check("collision", field_value, model);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Verdict
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clock       = 1'b0;
        reset_n     = 1'b0;
        sw_req      = '0;
        hw_upd      = '0;
        ext_value   = 4'h0;
        miscompares = 0;
        check_count = 0;
        cycles      = 0;
        t_reset(4'ha);
        t_sw_write();
        t_hw_update();
        t_collide();
        t_reset(4'h3);
        t_sw_write();
        conclude();
    end
endmodule
`default_nettype wire
